/* hdl/bsr_pkg.sv */
// Purpose: shared constants and carriers for the board system register bank
// Assumes: 50 MHz clock, 8-bit I/O cycles in a 16-bit I/O space
// Notes:   offsets are absolute I/O addresses
package bsr_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [15:0] BSR_OFF_STATUS     = 16'h8200;
    localparam logic [15:0] BSR_OFF_CONTROL    = 16'h8201;
    localparam logic [15:0] BSR_OFF_CLASS      = 16'h8202;
    localparam logic [15:0] BSR_OFF_SPARE_A    = 16'h8203;
    localparam logic [15:0] BSR_OFF_VARIANT    = 16'h8204;
    localparam logic [15:0] BSR_OFF_SETUP      = 16'h8205;
    localparam logic [15:0] BSR_OFF_REVISION   = 16'h8206;
    localparam logic [15:0] BSR_OFF_SOCK_CFG   = 16'h8207;
    localparam logic [15:0] BSR_OFF_SOCK_PAGE  = 16'h8208;
    localparam logic [15:0] BSR_OFF_SOCK_BASE  = 16'h8209;
    localparam logic [15:0] BSR_OFF_BOOT       = 16'h820a;
    localparam logic [15:0] BSR_OFF_SENSOR_BUS = 16'h820b;
    localparam logic [15:0] BSR_OFF_SWITCHES   = 16'h820c;
    localparam logic [15:0] BSR_OFF_LAST       = 16'h821f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BSR_CTL_SRC_SEL  = 3;
    localparam int BSR_CTL_HALT     = 4;
    localparam int BSR_CTL_ACTION   = 5;
    localparam int BSR_CTL_KICK     = 6;
    localparam int BSR_CTL_TRIGGER  = 7;
    localparam int BSR_SET_WD_RUN   = 6;
    localparam int BSR_SET_READY    = 7;
    localparam int BSR_SOCK_EN      = 7;
    localparam int BSR_SOCK_SIZE    = 0;
    localparam int BSR_SB_SCL_LATCH = 7;
    localparam int BSR_SB_SDA_LATCH = 6;

    // ------------------------------------------------------------
    // values after reset and magic values
    // ------------------------------------------------------------
    localparam logic [7:0] BSR_CONTROL_RESET   = 8'h05;
    localparam logic [7:0] BSR_SETUP_RESET     = 8'h00;
    localparam logic [7:0] BSR_SOCK_CFG_RESET  = 8'h00;
    localparam logic [7:0] BSR_SOCK_PAGE_RESET = 8'h00;
    localparam logic [7:0] BSR_SOCK_BASE_RESET = 8'hd0;
    localparam logic [7:0] BSR_RESET_MAGIC     = 8'ha5;
    // identity defaults, values arbitrary
    localparam logic [7:0] BSR_CLASS_DEFAULT    = 8'h3c;
    localparam logic [7:0] BSR_VARIANT_DEFAULT  = 8'h6e;
    localparam logic [7:0] BSR_REVISION_DEFAULT = 8'h01;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int BSR_CLK_HZ         = 50_000_000;
    localparam int BSR_WDOG_TIMEOUT_MS = 1000;
    localparam int BSR_WDOG_CYCLES    =
        BSR_WDOG_TIMEOUT_MS * (BSR_CLK_HZ / 1000);
    localparam int BSR_WDOG_W         = 26;
    localparam int BSR_RST_PULSE_NS   = 1000;
    localparam int BSR_RST_PULSE_CYCLES =
        (BSR_RST_PULSE_NS * (BSR_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int BSR_RST_CNT_W      = 6;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } bsr_io_req_s;

    typedef struct packed {
        logic       supply_fault_n;
        logic       error_irq_pending_n;
        logic       battery_low_n;
        logic       temp_limit_n;
        logic       clock_chip_square_wave;
        logic       timer2_out;
        logic       speaker_enable;
        logic       scl_in;
        logic       sda_in;
        logic [1:0] boot_mode;
        logic [7:0] switches;
    } bsr_pins_s;

    localparam int BSR_PINS_W = 19;

endpackage

/* hdl/bsr_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module bsr_sync #(
    parameter int           W         = 1,
    parameter logic [W-1:0] RESET_VAL = '1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } bsr_sync_s;

    bsr_sync_s st;
    bsr_sync_s next_st;

    always_comb begin
        next_st.meta   = d;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '{meta: RESET_VAL, stable: RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.stable;

endmodule
`default_nettype wire

/* hdl/bsr_regs.sv */
// Purpose: board system register bank on the host I/O cycle port
// Assumes: io strobes are one-cycle pulses on clk; pins are asynchronous
// Notes:   read data appears one edge after the read strobe
`timescale 1ns/100ps
`default_nettype none
module bsr_regs
    import bsr_pkg::*;
#(
    parameter int         WDOG_CYCLES   = bsr_pkg::BSR_WDOG_CYCLES,
    parameter logic [7:0] CLASS_CODE    = bsr_pkg::BSR_CLASS_DEFAULT,
    parameter logic [7:0] VARIANT_CODE  = bsr_pkg::BSR_VARIANT_DEFAULT,
    parameter logic [7:0] REVISION_CODE = bsr_pkg::BSR_REVISION_DEFAULT
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // host i/o cycles
    input  wire bsr_pkg::bsr_io_req_s io_req,
    output logic [7:0]                io_rdata,
    output logic                      io_rd_hit,
    // board pins in
    input  wire bsr_pkg::bsr_pins_s   pins,
    // board pins out
    output logic                      halt_line_n,
    output logic                      trigger_out_n,
    output logic                      hw_reset_out,
    output logic                      ready_out,
    // socket window setup
    output logic                      sock_en,
    output logic                      sock_size,
    output logic [2:0]                sock_page,
    output logic [5:0]                sock_base,
    // sensor bus, open drain
    output logic                      scl_out,
    output logic                      scl_oe,
    output logic                      sda_out,
    output logic                      sda_oe
);
    import bsr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                     halt;
        logic                     kick;
        logic                     src_sel;
        logic                     trig;
        logic                     wd_run;
        logic                     ready;
        logic                     sock_en;
        logic                     sock_size;
        logic [2:0]               page;
        logic [5:0]               base;
        logic                     scl_oe;
        logic                     sda_oe;
        logic                     wd_expired;
        logic [BSR_WDOG_W-1:0]    wd_cnt;
        logic [BSR_RST_CNT_W-1:0] rst_cnt;
        logic [7:0]               rdata;
        logic                     rd_hit;
        logic                     halt_n;
        logic                     trig_out;
        logic                     rst_out;
    } bsr_state_s;
    localparam bsr_state_s ST_RESET = '{
        halt:       BSR_CONTROL_RESET[BSR_CTL_HALT],
        kick:       BSR_CONTROL_RESET[BSR_CTL_KICK],
        src_sel:    1'b1,
        trig:       1'b1,
        wd_run:     BSR_SETUP_RESET[BSR_SET_WD_RUN],
        ready:      BSR_SETUP_RESET[BSR_SET_READY],
        sock_en:    BSR_SOCK_CFG_RESET[BSR_SOCK_EN],
        sock_size:  BSR_SOCK_CFG_RESET[BSR_SOCK_SIZE],
        page:       BSR_SOCK_PAGE_RESET[2:0],
        base:       BSR_SOCK_BASE_RESET[5:0],
        scl_oe:     1'b0,
        sda_oe:     1'b0,
        wd_expired: 1'b0,
        wd_cnt:     '0,
        rst_cnt:    '0,
        rdata:      8'h00,
        rd_hit:     1'b0,
        halt_n:     1'b1,
        trig_out:   1'b1,
        rst_out:    1'b0
    };
    localparam logic [BSR_WDOG_W-1:0] WD_LAST =
        BSR_WDOG_W'(WDOG_CYCLES - 1);
    localparam logic [BSR_RST_CNT_W-1:0] RST_LOAD =
        BSR_RST_CNT_W'(BSR_RST_PULSE_CYCLES);
    bsr_state_s st;
    bsr_state_s next_st;
    bsr_pins_s  pins_q;
    logic       in_bank;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    bsr_sync #(
        .W         (BSR_PINS_W),
        .RESET_VAL ('1)
    ) u_pin_sync (
        .clk   (clk),
        .reset (reset),
        .d     (pins),
        .q     (pins_q)
    );
    assign in_bank = (io_req.addr >= BSR_OFF_STATUS)
                  && (io_req.addr <= BSR_OFF_LAST);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rv;
        logic       kicked;
        logic       magic;
        rv      = 8'h00;
        kicked  = 1'b0;
        magic   = 1'b0;
        next_st = st;
        if (st.rst_cnt != '0) begin
            next_st.rst_cnt = st.rst_cnt - 1'b1;
        end

        // status and class writes fall to default: nothing stored
        if (io_req.wr && in_bank) begin
            unique case (io_req.addr)
                BSR_OFF_CONTROL: begin
                    next_st.halt    = io_req.wdata[BSR_CTL_HALT];
                    kicked = io_req.wdata[BSR_CTL_KICK] != st.kick;
                    next_st.kick    = io_req.wdata[BSR_CTL_KICK];
                    next_st.src_sel = io_req.wdata[BSR_CTL_SRC_SEL];
                    next_st.trig    = io_req.wdata[BSR_CTL_TRIGGER];
                end
                BSR_OFF_SETUP: begin
                    if (io_req.wdata[BSR_SET_WD_RUN]) begin
                        next_st.wd_run = 1'b1;
                    end
                    next_st.ready = io_req.wdata[BSR_SET_READY];
                end
                BSR_OFF_SOCK_CFG: begin
                    next_st.sock_en   = io_req.wdata[BSR_SOCK_EN];
                    next_st.sock_size = io_req.wdata[BSR_SOCK_SIZE];
                end
                BSR_OFF_SOCK_PAGE: next_st.page = io_req.wdata[2:0];
                BSR_OFF_SOCK_BASE: next_st.base = io_req.wdata[5:0];
                BSR_OFF_SENSOR_BUS: begin
                    // latch low means the pin is pulled down
                    next_st.scl_oe = ~io_req.wdata[BSR_SB_SCL_LATCH];
                    next_st.sda_oe = ~io_req.wdata[BSR_SB_SDA_LATCH];
                end
                BSR_OFF_VARIANT: begin
                    magic = io_req.wdata == BSR_RESET_MAGIC;
                end
                default: ;
            endcase
        end
        // expiry always ends in hardware reset
        if (st.wd_run && !st.wd_expired) begin
            if (kicked) begin
                next_st.wd_cnt = '0;
            end else if (st.wd_cnt == WD_LAST) begin
                next_st.wd_expired = 1'b1;
                next_st.wd_cnt     = '0;
                next_st.rst_cnt    = RST_LOAD;
            end else begin
                next_st.wd_cnt = st.wd_cnt + 1'b1;
            end
        end
        if (magic) begin
            next_st         = ST_RESET;
            next_st.rst_cnt = RST_LOAD;
        end
        unique case (io_req.addr)
            BSR_OFF_STATUS: begin
                rv = {pins_q.temp_limit_n, pins_q.battery_low_n, 1'b1,
                      ~st.wd_expired, 1'b1, 1'b1,
                      pins_q.error_irq_pending_n, pins_q.supply_fault_n};
            end
            BSR_OFF_CONTROL: begin
                rv = {1'b1, st.kick, 1'b0, st.halt, 1'b1, 1'b1, 1'b0,
                      1'b1};
            end
            BSR_OFF_CLASS:     rv = CLASS_CODE;
            BSR_OFF_VARIANT:   rv = VARIANT_CODE;
            BSR_OFF_SETUP:     rv = {st.ready, st.wd_run, 6'h00};
            BSR_OFF_REVISION:  rv = REVISION_CODE;
            BSR_OFF_SOCK_CFG:  rv = {st.sock_en, 6'h00, st.sock_size};
            BSR_OFF_SOCK_PAGE: rv = {5'h00, st.page};
            BSR_OFF_SOCK_BASE: rv = {2'h3, st.base};
            BSR_OFF_BOOT:      rv = {6'h00, pins_q.boot_mode};
            BSR_OFF_SENSOR_BUS: begin
                rv = {~st.scl_oe, ~st.sda_oe, pins_q.scl_in,
                      pins_q.sda_in, 4'hf};
            end
            BSR_OFF_SWITCHES:  rv = pins_q.switches;
            default:           rv = 8'h00;
        endcase
        if (io_req.rd) begin
            next_st.rdata  = in_bank ? rv : 8'h00;
            next_st.rd_hit = in_bank;
        end else begin
            next_st.rd_hit = 1'b0;
        end
        next_st.halt_n = ~next_st.halt;
        if (next_st.src_sel) begin
            next_st.trig_out = next_st.trig;
        end else if (!next_st.trig) begin
            next_st.trig_out = pins_q.clock_chip_square_wave;
        end else begin
            next_st.trig_out = pins_q.timer2_out & pins_q.speaker_enable;
        end
        next_st.rst_out = next_st.rst_cnt != '0;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign io_rdata      = st.rdata;
    assign io_rd_hit     = st.rd_hit;
    assign halt_line_n   = st.halt_n;
    assign trigger_out_n = st.trig_out;
    assign hw_reset_out  = st.rst_out;
    assign ready_out     = st.ready;
    assign sock_en       = st.sock_en;
    assign sock_size     = st.sock_size;
    assign sock_page     = st.page;
    assign sock_base     = st.base;
    assign scl_out       = 1'b0;
    assign scl_oe        = st.scl_oe;
    assign sda_out       = 1'b0;
    assign sda_oe        = st.sda_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_STATUS_PINS: assert property (
        @(posedge clk) disable iff (reset)
        (io_req.rd && io_req.addr == BSR_OFF_STATUS) |=>
        (io_rdata[0] == $past(pins_q.supply_fault_n)
         && io_rdata[1] == $past(pins_q.error_irq_pending_n)
         && io_rdata[7] == $past(pins_q.temp_limit_n)
         && io_rdata[6] == $past(pins_q.battery_low_n))
    ) else $error("status pin bits wrong");
    AST_STATUS_CONST: assert property (
        @(posedge clk) disable iff (reset)
        (io_req.rd && io_req.addr == BSR_OFF_STATUS) |=>
        (io_rdata[5] && io_rdata[3] && io_rdata[2]
         && io_rdata[4] == !$past(st.wd_expired))
    ) else $error("status constant or watchdog bit wrong");
    AST_WD_LATCH: assert property (
        @(posedge clk) disable iff (reset)
        (st.wd_expired && !(io_req.wr && io_req.addr == BSR_OFF_VARIANT
                            && io_req.wdata == BSR_RESET_MAGIC))
        |=> st.wd_expired
    ) else $error("watchdog flag dropped without reset");
    AST_CTRL_READ: assert property (
        @(posedge clk) disable iff (reset)
        (io_req.rd && io_req.addr == BSR_OFF_CONTROL) |=>
        (io_rdata[0] && !io_rdata[1] && io_rdata[2] && io_rdata[3]
         && io_rdata[7] && !io_rdata[5])
    ) else $error("control fixed bits wrong");
    AST_HALT: assert property (
        @(posedge clk) disable iff (reset)
        (io_req.wr && io_req.addr == BSR_OFF_CONTROL) |=>
        (halt_line_n == !$past(io_req.wdata[BSR_CTL_HALT]))
        ##1 (halt_line_n == st.halt_n)
    ) else $error("halt line not following control bit");
    AST_EXPIRY_RESET: assert property (
        @(posedge clk) disable iff (reset)
        $rose(st.wd_expired) |-> hw_reset_out [*8]
    ) else $error("expiry without reset pulse");
    AST_KICK: assert property (
        @(posedge clk) disable iff (reset)
        (io_req.wr && io_req.addr == BSR_OFF_CONTROL && st.wd_run
         && !st.wd_expired
         && io_req.wdata[BSR_CTL_KICK] != st.kick)
        |=> (st.wd_cnt == '0) ##1 (st.wd_cnt <= 1)
    ) else $error("kick did not restart watchdog");
    AST_MAGIC: assert property (
        @(posedge clk) disable iff (reset)
        (io_req.wr && io_req.addr == BSR_OFF_VARIANT
         && io_req.wdata == BSR_RESET_MAGIC)
        |=> (hw_reset_out && !st.wd_expired && !st.wd_run)
    ) else $error("magic write did not reset");
    AST_RESERVED: assert property (
        @(posedge clk) disable iff (reset)
        (io_req.rd && (io_req.addr == BSR_OFF_SPARE_A
         || (io_req.addr > BSR_OFF_SWITCHES
             && io_req.addr <= BSR_OFF_LAST)))
        |=> (io_rdata == 8'h00 && io_rd_hit)
    ) else $error("reserved read not zero");
    AST_WD_STICKY: assert property (
        @(posedge clk) disable iff (reset)
        (st.wd_run && !(io_req.wr && io_req.addr == BSR_OFF_VARIANT
                        && io_req.wdata == BSR_RESET_MAGIC))
        |=> st.wd_run
    ) else $error("watchdog run enable cleared");
endmodule
`default_nettype wire

/* sim/bsr_host.sv */
// Purpose: host model issuing byte i/o read and write cycles
// Assumes: one-cycle strobes launched at the falling edge of clk
// Notes:   released address and data lines show their inverse
`timescale 1ns/100ps
`default_nettype none
module bsr_host (
    // clock
    input  wire logic                clk,
    // i/o cycle
    output var bsr_pkg::bsr_io_req_s io_req
);
    import bsr_pkg::*;

    initial io_req = '0;

    // ------------------------------------------------------------
    // one access, held across the taking edge
    // ------------------------------------------------------------
    task automatic cycle(input logic [15:0] a, input logic [7:0] d,
                         input logic w);
        logic [7:0] wd;
        wd = d;
        if (w && a == BSR_OFF_STATUS)
            wd = 8'h00;
        if (w && a == BSR_OFF_CONTROL)
            wd[BSR_CTL_ACTION] = 1'b0;
        @(negedge clk);
        io_req.addr  = a;
        io_req.wdata = wd;
        io_req.rd = !w;
        io_req.wr = w;
        @(negedge clk);
        io_req.rd    = 1'b0;
        io_req.wr    = 1'b0;
        // stale lines must not look valid
        io_req.addr  = ~io_req.addr;
        io_req.wdata = ~io_req.wdata;
    endtask
endmodule
`default_nettype wire

/* sim/bsr_regs_tb_top.sv */
// Purpose: self-checking bench for the board system register bank
// Assumes: watchdog shortened to WD cycles
// Notes:   expected read data is queued and checked by a watcher process
`timescale 1ns/100ps
`default_nettype none
module bsr_regs_tb_top;
    import bsr_pkg::*;

    localparam int WD = 200;
    logic                clk = 1'b0;
    logic                reset;
    bsr_io_req_s         io_req;
    bsr_pins_s           pins;
    logic [7:0]          io_rdata;
    logic                io_rd_hit;
    logic                halt_line_n;
    logic                trigger_out_n;
    logic                hw_reset_out;
    logic                ready_out;
    logic                sock_en;
    logic                sock_size;
    logic [2:0]          sock_page;
    logic [5:0]          sock_base;
    logic                scl_out;
    logic                scl_oe;
    logic                sda_out;
    logic                sda_oe;
    logic [7:0]          exp_q[$];
    logic [31:0]         lfsr = 32'hc007;
    int                  err_count = 0;
    int                  comparisons = 0;
    int                  k;

    always #10 clk = ~clk;

    bsr_host host (.clk(clk), .io_req(io_req));

    bsr_regs #(.WDOG_CYCLES(WD)) uut (
        .clk(clk), .reset(reset), .io_req(io_req), .io_rdata(io_rdata),
        .io_rd_hit(io_rd_hit), .pins(pins), .halt_line_n(halt_line_n),
        .trigger_out_n(trigger_out_n), .hw_reset_out(hw_reset_out),
        .ready_out(ready_out), .sock_en(sock_en), .sock_size(sock_size),
        .sock_page(sock_page), .sock_base(sock_base), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.cycle(a, 8'h00, 1'b0);
    endtask

    task automatic summarize();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // read data watcher
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (io_rd_hit === 1'b1) begin
            if (exp_q.size() == 0)
                chk8("unexpected_read", 8'h00, 8'hff);
            else
                chk8("io_rdata", exp_q.pop_front(), io_rdata);
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        pins = '1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        rd(BSR_OFF_CONTROL, 8'h8d);
        rd(BSR_OFF_SETUP, BSR_SETUP_RESET);
        rd(BSR_OFF_SOCK_BASE, BSR_SOCK_BASE_RESET);
        host.cycle(BSR_OFF_CLASS, 8'h00, 1'b1);
        rd(BSR_OFF_CLASS, BSR_CLASS_DEFAULT);
        rd(BSR_OFF_VARIANT, BSR_VARIANT_DEFAULT);
        host.cycle(BSR_OFF_SPARE_A, 8'hff, 1'b1);
        rd(BSR_OFF_SPARE_A, 8'h00);
        rd(16'h821f, 8'h00);
        host.cycle(BSR_OFF_SOCK_PAGE, 8'h05, 1'b1);
        rd(BSR_OFF_SOCK_PAGE, 8'h05);
        chk8("sock_page", 8'h05, {3'h0, scl_out, sda_out, sock_page});
        chk8("sock_window", {BSR_SOCK_CFG_RESET[BSR_SOCK_EN],
            BSR_SOCK_CFG_RESET[BSR_SOCK_SIZE], BSR_SOCK_BASE_RESET[5:0]},
            {sock_en, sock_size, sock_base});
        rd(BSR_OFF_SOCK_CFG, BSR_SOCK_CFG_RESET);
        host.cycle(BSR_OFF_STATUS, 8'hff, 1'b1);
        rd(BSR_OFF_STATUS, 8'hff);
        rd(BSR_OFF_REVISION, BSR_REVISION_DEFAULT);
        rd(BSR_OFF_BOOT, 8'h03);
        // latch low on the clock line pulls it down
        host.cycle(BSR_OFF_SENSOR_BUS, 8'h40, 1'b1);
        chk8("sensor_oe", 8'h02, {6'h00, scl_oe, sda_oe});
        rd(BSR_OFF_SENSOR_BUS, 8'h7f);
        // random pin levels reach every flag
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            pins = lfsr[18:0];
            repeat (3) @(negedge clk);
            rd(BSR_OFF_STATUS, {pins.temp_limit_n, pins.battery_low_n,
                4'hf, pins.error_irq_pending_n, pins.supply_fault_n});
            rd(BSR_OFF_SWITCHES, pins.switches);
        end
        host.cycle(BSR_OFF_CONTROL, 8'h12, 1'b1);
        chk1("halt_line_n", 1'b0, halt_line_n);
        rd(BSR_OFF_CONTROL, 8'h9d);
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            pins = lfsr[18:0];
            host.cycle(BSR_OFF_CONTROL, {i[0], 3'b000, i[1], 3'b000}, 1'b1);
            repeat (3) @(negedge clk);
            chk1("trigger_out_n", i[1] ? i[0] : (i[0] ? pins.timer2_out &
                pins.speaker_enable : pins.clock_chip_square_wave),
                trigger_out_n);
        end
        chk1("halt_line_n", 1'b1, halt_line_n);
        pins = '1;
        host.cycle(BSR_OFF_SETUP, 8'hc0, 1'b1);
        chk1("ready_out", 1'b1, ready_out);
        host.cycle(BSR_OFF_SETUP, 8'h00, 1'b1);
        rd(BSR_OFF_SETUP, 8'h40);
        // kicks closer than the timeout keep it alive
        for (int i = 1; i <= 3; i++) begin
            repeat (WD - 60) @(negedge clk);
            host.cycle(BSR_OFF_CONTROL, {1'b0, i[0], 6'h00}, 1'b1);
        end
        rd(BSR_OFF_STATUS, 8'hff);
        for (k = 0; k < WD + 20 && hw_reset_out !== 1'b1; k++)
            @(negedge clk);
        chk1("expiry_time", 1'b1, k > WD - 20 && k < WD + 20);
        for (k = 0; k < 100 && hw_reset_out === 1'b1; k++)
            @(negedge clk);
        chk8("reset_pulse_len", 8'(BSR_RST_PULSE_CYCLES), k[7:0]);
        rd(BSR_OFF_STATUS, 8'hef);
        repeat (100) @(negedge clk);
        rd(BSR_OFF_STATUS, 8'hef);
        host.cycle(BSR_OFF_CONTROL, 8'h10, 1'b1);
        host.cycle(BSR_OFF_VARIANT, 8'h5a, 1'b1);
        chk1("hw_reset_out", 1'b0, hw_reset_out);
        rd(BSR_OFF_STATUS, 8'hef);
        host.cycle(BSR_OFF_VARIANT, BSR_RESET_MAGIC, 1'b1);
        chk1("hw_reset_out", 1'b1, hw_reset_out);
        repeat (60) @(negedge clk);
        chk1("halt_line_n", 1'b1, halt_line_n);
        rd(BSR_OFF_STATUS, 8'hff);
        rd(BSR_OFF_SETUP, 8'h00);
        rd(BSR_OFF_SOCK_PAGE, BSR_SOCK_PAGE_RESET);
        rd(BSR_OFF_SENSOR_BUS, 8'hff);
        for (k = 0; k < 20 && exp_q.size() != 0; k++)
            @(negedge clk);
        if (exp_q.size() != 0)
            chk8("pending_reads", 8'h00, 8'(exp_q.size()));
        summarize();
    end
endmodule
`default_nettype wire
